// [lcm_lane_ctrl.sv]
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
package lcm_pkg;
    localparam int NSIDE = 2;
    localparam int NLANE = 4;
    localparam int NCH = NSIDE * NLANE;
    localparam int NSYNC = 15;
    localparam int CNT_W = 8;
    localparam int CLK_NS = 20;
    localparam int GEN2_MAX_NS = 200;
    localparam int GEN2_MAX_CYC = GEN2_MAX_NS / CLK_NS;
    localparam logic [3:0] IDX_STATUS = 4'h0;
    localparam logic [3:0] IDX_RATE = 4'h1;
    localparam logic [3:0] IDX_IDLE = 4'h2;
    localparam logic [3:0] IDX_LANE0 = 4'h8;
    localparam logic [7:0] LANE_RST = 8'h00;
    localparam logic [7:0] RATE_RST = 8'hAA;
    localparam logic [7:0] IDLE_RST = 8'h00;
    localparam logic [1:0] VOD_PIN = 2'h0;
    localparam logic [7:0] IDLE_PIN = 8'h00;
    localparam logic [2:0] SMB_ADDR_HI = 3'h5;
    localparam logic [1:0] RATE_GEN1 = 2'h0;
    localparam logic [1:0] RATE_GEN2 = 2'h1;
    localparam logic [1:0] RATE_AUTO = 2'h2;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    typedef struct packed {
        logic [1:0] vod;
        logic [2:0] deemph;
        logic [2:0] eq;
    } lcm_lane_cfg_t;
    typedef struct packed {
        logic [1:0] eq_a;
        logic [1:0] eq_b;
        logic [1:0] dem_a;
        logic [1:0] dem_b;
    } lcm_straps_t;
    typedef enum logic [8:0] {
        S_IDLE = 9'h001,
        S_ADDR = 9'h002,
        S_ACKA = 9'h004,
        S_CMD = 9'h008,
        S_ACKC = 9'h010,
        S_DATA = 9'h020,
        S_ACKD = 9'h040,
        S_TX = 9'h080,
        S_RACK = 9'h100
    } lcm_smb_st_t;
endpackage
// Notes on behaviour
// - With the mode input high, the control registers for equalization, de-emphasis, swing, rate and idle are reachable.
// - With the mode input low, register access other than to the status register is refused and eq and de-emphasis come from the straps.
// - With the mode input at 1, the shared clock pin serves as the management bus clock input.
// - In register mode the data pin is read as input and only ever pulled low, never driven high.
// - In register mode the four address straps set the slave address, and the host must use that address.
// - The side A and side B equalization straps count only while the mode input is low.
// - In pin mode one strap level applies alike to all four lanes of its side.
// - In register mode each lane takes its own settings from its own register.
// - In register mode the two side B equalization straps become the upper two address bits.
// - The device detects a second-generation stream per side and sets that side's de-emphasis timing to match.
// - De-emphasis straps count only in pin mode; in register mode they are clock, data and lower address bits.
// - In pin mode the rate pin forces first or second generation, and when floating the rate is detected after idle.
// - With the mode input at 1 the rate pin is ignored and rate comes from the registers.
module lcm_lane_ctrl import lcm_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int GEN2_MAX = GEN2_MAX_CYC
) (
    input wire logic pclk, // 50 MHz clock
    input wire logic presetn, // async reset, low
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error
    input wire logic config_bus_mode_select, // 1 = register mode
    input wire logic [1:0] side_a_equalizer_level_straps, // eq level, side a
    input wire logic [1:0] side_b_equalizer_level_straps, // eq level, side b / addr hi
    input wire logic [1:0] side_a_deemphasis_level_straps, // de-emph a / scl, sda in
    input wire logic [1:0] side_b_deemphasis_level_straps, // de-emph b / addr lo
    output logic sda_out, // sda drive level
    output logic sda_oe, // sda pull enable
    input wire logic rate_select_pin, // forced rate level
    input wire logic rate_select_float, // rate pin left open
    input wire logic [1:0] rx_rate_clk, // recovered clock per side
    input wire logic [1:0] rx_idle, // electrical idle per side
    output lcm_lane_cfg_t [NCH-1:0] lane_cfg, // per-lane settings
    output logic [1:0] side_gen2, // de-emph timing gen2
    output logic [7:0] idle_threshold, // idle detect setting
    output logic register_mode // current mode
);
    if (ADDR_W < 7 || GEN2_MAX < 1 || GEN2_MAX > 254) begin : g_chk
        $error("lcm_lane_ctrl: unsupported parameter value");
    end

    logic [NSYNC-1:0] pin_raw, sync1_r, sync2_r;
    lcm_straps_t straps_s;
    logic mode_s, rate_pin_s, rate_flt_s;
    logic [1:0] rclk_s, idle_s;
    logic mode_r;
    logic [7:0] rate_reg_r, idle_reg_r;
    lcm_lane_cfg_t [NCH-1:0] lane_reg_r;
    lcm_lane_cfg_t [NCH-1:0] lane_cfg_r;
    logic [1:0] det_gen2;
    logic [1:0] gen2_r;
    logic [7:0] idle_th_r;
    logic sda_oe_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;
    logic [3:0] idx;
    logic mapped, allowed, apb_req, apb_we;
    logic smb_oe, smb_we;
    logic [7:0] smb_cmd, smb_wd, smb_rd;
    logic smb_hit;
    logic [6:0] slave_addr;

    assign pin_raw = {rx_idle, rx_rate_clk, rate_select_float, rate_select_pin, config_bus_mode_select,
                      side_a_equalizer_level_straps, side_b_equalizer_level_straps,
                      side_a_deemphasis_level_straps, side_b_deemphasis_level_straps};

    // every pin crosses two flops before use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
        end
    end

    assign straps_s = sync2_r[7:0];
    assign mode_s = sync2_r[8];
    assign rate_pin_s = sync2_r[9];
    assign rate_flt_s = sync2_r[10];
    assign rclk_s = sync2_r[12:11];
    assign idle_s = sync2_r[14:13];

    // reset and pulldown mean pin mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_r <= 1'b0;
        end else begin
            mode_r <= mode_s;
        end
    end

    // side b eq straps give the top two bits
    assign slave_addr = {SMB_ADDR_HI, straps_s.eq_b[0], straps_s.eq_b[1],
                         straps_s.dem_b[0], straps_s.dem_b[1]};

    // scl taken from the shared pin
    // de-emphasis a straps carry scl and sda
    lcm_smb_slave u_smb (
        .pclk(pclk),
        .presetn(presetn),
        .en(mode_r),
        .scl(straps_s.dem_a[1]),
        .sda(straps_s.dem_a[0]),
        .dev_addr(slave_addr),
        .rd_data(smb_rd),
        .sda_oe(smb_oe),
        .wr_en(smb_we),
        .cmd(smb_cmd),
        .wr_data(smb_wd)
    );

    // open drain, only ever pulls low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= smb_oe & mode_r;
        end
    end

    assign smb_hit = (smb_cmd[7:4] == 4'h0);

    function automatic logic [7:0] reg_read(input logic [3:0] i);
        logic [7:0] v;
        v = 8'h00;
        if (i == IDX_STATUS) begin
            v = {5'h00, det_gen2, mode_r};
        end else if (i == IDX_RATE) begin
            v = rate_reg_r;
        end else if (i == IDX_IDLE) begin
            v = idle_reg_r;
        end else if (i >= IDX_LANE0) begin
            v = lane_reg_r[i[2:0]];
        end
        return v;
    endfunction

    always_comb smb_rd = smb_hit ? reg_read(smb_cmd[3:0]) : 8'h00;
    assign idx = paddr[5:2];

    // full map only in register mode
    // pin mode refuses all but status
    always_comb begin
        mapped = (paddr[ADDR_W-1:6] == '0) &&
                 (idx == IDX_STATUS || idx == IDX_RATE || idx == IDX_IDLE || idx >= IDX_LANE0);
        allowed = mapped && (mode_r || idx == IDX_STATUS);
    end

    // one wait state, so pready answers in the second access cycle
    assign apb_req = psel & penable & ~pready_r;
    assign apb_we = psel & penable & pready_r & pwrite & allowed & (idx != IDX_STATUS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h00000000;
        end else begin
            pready_r <= apb_req;
            pslverr_r <= apb_req & ~allowed;
            if (apb_req && allowed && !pwrite) begin
                prdata_r <= {24'h000000, reg_read(idx)};
            end else begin
                prdata_r <= 32'h00000000;
            end
        end
    end

    // a same-cycle write from both buses to one register keeps the smbus byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_reg_r <= RATE_RST;
            idle_reg_r <= IDLE_RST;
        end else begin
            if (smb_we && smb_hit && smb_cmd[3:0] == IDX_RATE) begin
                rate_reg_r <= smb_wd;
            end else if (apb_we && idx == IDX_RATE) begin
                rate_reg_r <= pwdata[7:0];
            end
            if (smb_we && smb_hit && smb_cmd[3:0] == IDX_IDLE) begin
                idle_reg_r <= smb_wd;
            end else if (apb_we && idx == IDX_IDLE) begin
                idle_reg_r <= pwdata[7:0];
            end
        end
    end

    for (genvar c = 0; c < NCH; c++) begin : g_lane
        localparam logic [3:0] LIDX = IDX_LANE0 + 4'(c);
        localparam int SIDE = c / NLANE;
        logic [1:0] eq_pin, dem_pin;
        assign eq_pin = (SIDE == 0) ? straps_s.eq_a : straps_s.eq_b;
        assign dem_pin = (SIDE == 0) ? straps_s.dem_a : straps_s.dem_b;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lane_reg_r[c] <= LANE_RST;
            end else if (smb_we && smb_hit && smb_cmd[3:0] == LIDX) begin
                lane_reg_r[c] <= smb_wd;
            end else if (apb_we && idx == LIDX) begin
                lane_reg_r[c] <= pwdata[7:0];
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                lane_cfg_r[c] <= LANE_RST;
            end else if (mode_r) begin
                // each lane from its own register
                lane_cfg_r[c] <= lane_reg_r[c];
            end else begin
                // eq straps used only in pin mode
                // one level for all lanes of a side
                // de-emphasis straps used only in pin mode
                lane_cfg_r[c].vod <= VOD_PIN;
                lane_cfg_r[c].deemph <= {1'b0, dem_pin};
                lane_cfg_r[c].eq <= {1'b0, eq_pin};
            end
        end
    end

    // rate detector: period of the recovered clock, rearmed on each idle exit
    for (genvar s = 0; s < NSIDE; s++) begin : g_rate
        logic rclk_q, idle_q, armed_r, seen_r, det_r;
        logic [CNT_W-1:0] cnt_r;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                rclk_q <= 1'b0;
                idle_q <= 1'b0;
            end else begin
                rclk_q <= rclk_s[s];
                idle_q <= idle_s[s];
            end
        end

        // gen2 when the period fits the bound
        // measure again after each exit from idle
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                armed_r <= 1'b1;
                seen_r <= 1'b0;
                det_r <= 1'b0;
                cnt_r <= '0;
            end else if (idle_q && !idle_s[s]) begin
                armed_r <= 1'b1;
                seen_r <= 1'b0;
                cnt_r <= '0;
            end else if (armed_r) begin
                if (cnt_r != '1) begin
                    cnt_r <= cnt_r + 1'b1;
                end
                if (rclk_s[s] && !rclk_q) begin
                    if (!seen_r) begin
                        seen_r <= 1'b1;
                        cnt_r <= '0;
                    end else begin
                        det_r <= (cnt_r < CNT_W'(GEN2_MAX));
                        armed_r <= 1'b0;
                    end
                end
            end
        end

        assign det_gen2[s] = det_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen2_r <= 2'b00;
        end else begin
            for (int s = 0; s < NSIDE; s++) begin
                logic [1:0] rm;
                rm = RATE_AUTO;
                if (mode_r) begin
                    rm = rate_reg_r[2*s+:2];
                end else if (!rate_flt_s) begin
                    rm = {1'b0, rate_pin_s};
                end
                if (rm == RATE_GEN1) begin
                    gen2_r[s] <= 1'b0;
                end else if (rm == RATE_GEN2) begin
                    gen2_r[s] <= 1'b1;
                end else begin
                    gen2_r[s] <= det_gen2[s];
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_th_r <= IDLE_PIN;
        end else begin
            idle_th_r <= mode_r ? idle_reg_r : IDLE_PIN;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;
    assign lane_cfg = lane_cfg_r;
    assign side_gen2 = gen2_r;
    assign idle_threshold = idle_th_r;
    assign register_mode = mode_r;
endmodule

// [lcm_lane_ctrl_properties.sv]
`timescale 1ns/1ps
module lcm_lane_ctrl_properties import lcm_pkg::*; #(
    parameter int ADDR_W = 8,
    parameter int GEN2_MAX = GEN2_MAX_CYC
) (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, low
    input wire logic [ADDR_W-1:0] paddr, // apb address
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic config_bus_mode_select, // mode pin
    input wire logic [1:0] side_a_equalizer_level_straps, // eq a
    input wire logic [1:0] side_a_deemphasis_level_straps, // dem a
    input wire logic rate_select_pin, // rate level
    input wire logic rate_select_float, // rate open
    input wire logic sda_out, // sda level
    input wire logic sda_oe, // sda pull
    input wire lcm_lane_cfg_t [NCH-1:0] lane_cfg, // lanes
    input wire logic [1:0] side_gen2, // rate out
    input wire logic register_mode // mode out
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    // straps need two sync flops and an output flop, so five quiet cycles suffice
    sequence s_pin_hold;
        (!register_mode && $stable(side_a_equalizer_level_straps) && $stable(side_a_deemphasis_level_straps))[*5];
    endsequence
    sequence s_rate_hold;
        (!register_mode && !rate_select_float && $stable(rate_select_pin))[*5];
    endsequence
    a_sda_open_drain: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    a_sda_pin_quiet: assert property ((!register_mode)[*3] |-> !sda_oe)
        else $error("data pin pulled in pin mode");
    a_apb_one_wait: assert property (s_access |=> pready)
        else $error("apb answer late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_pin_refuse: assert property (s_access and (!register_mode && paddr[5:2] != 4'h0) |=> pslverr)
        else $error("register access not refused in pin mode");
    a_mode_follow: assert property (config_bus_mode_select[*5] |-> register_mode)
        else $error("register mode not entered");
    a_mode_default: assert property ((!config_bus_mode_select)[*5] |-> !register_mode)
        else $error("register mode without pin");
    a_side_a_pins: assert property (s_pin_hold |-> lane_cfg[NLANE-1:0] ==
        {NLANE{VOD_PIN, 1'b0, side_a_deemphasis_level_straps, 1'b0, side_a_equalizer_level_straps}})
        else $error("side a lanes differ from straps");
    a_rate_pin: assert property (s_rate_hold |-> side_gen2 == {2{rate_select_pin}})
        else $error("forced rate not applied");
endmodule
bind lcm_lane_ctrl lcm_lane_ctrl_properties #(.ADDR_W(ADDR_W), .GEN2_MAX(GEN2_MAX)) i_lcm_props (.*);

// [lcm_smb_host.sv]
`timescale 1ns/1ps
module lcm_smb_host (
    input wire logic pclk, // system clock
    input wire logic dev_pull, // device pulls data low
    output logic scl, // bus clock
    output wire logic sda_line // wired data line
);
    logic host_pull;
    logic [7:0] rx;
    assign sda_line = ~(host_pull | dev_pull);
    initial begin
        scl = 1'b1;
        host_pull = 1'b0;
    end
    task automatic half();
        repeat (6) @(posedge pclk);
    endtask
    task automatic start();
        host_pull <= 1'b1;
        half();
        scl <= 1'b0;
    endtask
    task automatic stop();
        @(posedge pclk);
        host_pull <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        host_pull <= 1'b0;
        half();
    endtask
    // data moves one edge after clock falls; ninth bit releases for ack
    task automatic wbyte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            @(posedge pclk);
            host_pull <= (i > 0) ? ~b[i-1] : 1'b0;
            half();
            scl <= 1'b1;
            half();
            if (i > 0) rx = {rx[6:0], sda_line};
            if (i == 0) ack = (sda_line === 1'b0);
            scl <= 1'b0;
        end
    endtask
endmodule

// [lcm_smb_slave.sv]
`timescale 1ns/1ps

module lcm_smb_slave import lcm_pkg::*; (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, low
    input wire logic en, // register mode
    input wire logic scl, // synchronised clock pin
    input wire logic sda, // synchronised data pin
    input wire logic [6:0] dev_addr, // own address
    input wire logic [7:0] rd_data, // byte at cmd
    output logic sda_oe, // pull data low
    output logic wr_en, // one-cycle write strobe
    output logic [7:0] cmd, // register index
    output logic [7:0] wr_data // write byte
);
    lcm_smb_st_t st_r;
    logic scl_q, sda_q, rw_r, nack_r;
    logic [7:0] shift_r;
    logic [3:0] bcnt_r;
    logic start, stop, rise, fall;

    assign start = en & scl & scl_q & sda_q & ~sda;
    assign stop = en & scl & scl_q & ~sda_q & sda;
    assign rise = scl & ~scl_q;
    assign fall = ~scl & scl_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end

    // bits are sampled on scl rise and driven after scl fall
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= S_IDLE;
            sda_oe <= 1'b0;
            wr_en <= 1'b0;
            cmd <= 8'h00;
            wr_data <= 8'h00;
            shift_r <= 8'h00;
            bcnt_r <= 4'h0;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
        end else begin
            wr_en <= 1'b0;
            if (!en || stop) begin
                st_r <= S_IDLE;
                sda_oe <= 1'b0;
            end else if (start) begin
                st_r <= S_ADDR;
                bcnt_r <= 4'h0;
                sda_oe <= 1'b0;
            end else if (rise) begin
                if ((st_r == S_ADDR || st_r == S_CMD || st_r == S_DATA) && bcnt_r != BITS_PER_BYTE) begin
                    shift_r <= {shift_r[6:0], sda};
                    bcnt_r <= bcnt_r + 4'h1;
                end
                if (st_r == S_RACK) begin
                    nack_r <= sda;
                end
            end else if (fall) begin
                case (st_r)
                    S_ADDR: begin
                        if (bcnt_r == BITS_PER_BYTE) begin
                            if (shift_r[7:1] == dev_addr) begin
                                rw_r <= shift_r[0];
                                sda_oe <= 1'b1;
                                st_r <= S_ACKA;
                            end else begin
                                st_r <= S_IDLE;
                            end
                        end
                    end
                    S_CMD: begin
                        if (bcnt_r == BITS_PER_BYTE) begin
                            cmd <= shift_r;
                            sda_oe <= 1'b1;
                            st_r <= S_ACKC;
                        end
                    end
                    S_DATA: begin
                        if (bcnt_r == BITS_PER_BYTE) begin
                            wr_data <= shift_r;
                            wr_en <= 1'b1;
                            sda_oe <= 1'b1;
                            st_r <= S_ACKD;
                        end
                    end
                    S_ACKA, S_RACK: begin
                        if ((st_r == S_ACKA && rw_r) || (st_r == S_RACK && !nack_r)) begin
                            shift_r <= rd_data;
                            sda_oe <= ~rd_data[7];
                            bcnt_r <= 4'h1;
                            st_r <= S_TX;
                        end else if (st_r == S_ACKA) begin
                            sda_oe <= 1'b0;
                            bcnt_r <= 4'h0;
                            st_r <= S_CMD;
                        end else begin
                            st_r <= S_IDLE;
                        end
                    end
                    S_ACKC, S_ACKD: begin
                        // successive data bytes go to successive registers
                        if (st_r == S_ACKD) begin
                            cmd <= cmd + 8'h01;
                        end
                        sda_oe <= 1'b0;
                        bcnt_r <= 4'h0;
                        st_r <= S_DATA;
                    end
                    S_TX: begin
                        if (bcnt_r == BITS_PER_BYTE) begin
                            sda_oe <= 1'b0;
                            cmd <= cmd + 8'h01;
                            st_r <= S_RACK;
                        end else begin
                            sda_oe <= ~shift_r[6];
                            shift_r <= {shift_r[6:0], 1'b0};
                            bcnt_r <= bcnt_r + 4'h1;
                        end
                    end
                    default: begin
                        st_r <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top import lcm_pkg::*;;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sda_out, sda_oe, register_mode;
    logic config_bus_mode_select, rate_select_pin, rate_select_float, smb_on, hscl, ack, err;
    logic [7:0] paddr, idle_threshold;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] side_a_equalizer_level_straps, side_b_equalizer_level_straps, side_b_deemphasis_level_straps;
    logic [1:0] dem_a, side_gen2, rx_rate_clk, rx_idle;
    wire logic [1:0] side_a_deemphasis_level_straps;
    wire logic sda_line;
    lcm_lane_cfg_t [NCH-1:0] lane_cfg;
    int num_errors, checked, cyc;
    assign side_a_deemphasis_level_straps = smb_on ? {hscl, sda_line} : dem_a;
    lcm_lane_ctrl i_lcm_lane_ctrl (.*);
    lcm_smb_host i_lcm_smb_host (.pclk(pclk), .dev_pull(sda_oe), .scl(hscl), .sda_line(sda_line));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        rx_rate_clk = 2'h0;
        #7;
        forever #80 rx_rate_clk = ~rx_rate_clk;
    end
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            num_errors++;
            print_verdict();
        end
    end
    task automatic t_pin();
        chk("mode", 32'h0, {31'h0, register_mode});
        for (int v = 0; v < 4; v++) begin
            side_a_equalizer_level_straps <= 2'(v);
            dem_a <= 2'(~v);
            side_b_equalizer_level_straps <= 2'(~v);
            side_b_deemphasis_level_straps <= 2'(v);
            wt(6);
            chk("lane3", {24'h0, VOD_PIN, 1'b0, 2'(~v), 1'b0, 2'(v)}, {24'h0, lane_cfg[3]});
            chk("lane4", {24'h0, VOD_PIN, 1'b0, 2'(v), 1'b0, 2'(~v)}, {24'h0, lane_cfg[4]});
        end
        rate_select_float <= 1'b0;
        rate_select_pin <= 1'b1;
        wt(6);
        chk("forced gen2", 32'h3, {30'h0, side_gen2});
        rate_select_float <= 1'b1;
        rx_idle <= 2'h3;
        wt(4);
        rx_idle <= 2'h0;
        wt(40);
        chk("detected gen2", 32'h3, {30'h0, side_gen2});
        apb(1'b0, 8'h04, 32'h0);
        chk("pin mode refusal", 32'h1, {31'h0, err});
    endtask
    task automatic t_reg();
        config_bus_mode_select <= 1'b1;
        rate_select_float <= 1'b0;
        wt(6);
        apb(1'b0, 8'h04, 32'h0);
        chk("rate reset", {24'h0, RATE_RST}, rd);
        apb(1'b1, 8'h34, 32'h5B);
        apb(1'b1, 8'h28, 32'hA5);
        apb(1'b0, 8'h34, 32'h0);
        chk("lane5 read", 32'h5B, rd);
        chk("lane5", 32'h5B, {24'h0, lane_cfg[5]});
        chk("lane4", 32'h0, {24'h0, lane_cfg[4]});
        side_a_equalizer_level_straps <= 2'h3;
        wt(6);
        chk("lane0", 32'h0, {24'h0, lane_cfg[0]});
        apb(1'b1, 8'h04, 32'h0);
        wt(2);
        chk("register rate", 32'h0, {30'h0, side_gen2});
        apb(1'b1, 8'h08, 32'h3C);
        wt(2);
        chk("idle", 32'h3C, {24'h0, idle_threshold});
        apb(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        apb(1'b0, 8'h40, 32'h0);
        chk("high address", 32'h1, {31'h0, err});
    endtask
    task automatic smb_wr(input logic [7:0] ab, input logic exp_ack);
        i_lcm_smb_host.start();
        i_lcm_smb_host.wbyte(ab, ack);
        chk("addr ack", {31'h0, exp_ack}, {31'h0, ack});
        if (ack === 1'b1) begin
            i_lcm_smb_host.wbyte(8'h09, ack);
            i_lcm_smb_host.wbyte(8'h3C, ack);
            chk("data ack", 32'h1, {31'h0, ack});
        end
        i_lcm_smb_host.stop();
    endtask
    task automatic t_smb();
        logic [6:0] a;
        // low address bits: eq_b[0], eq_b[1], dem_b[0], dem_b[1]
        side_b_equalizer_level_straps <= 2'b10;
        side_b_deemphasis_level_straps <= 2'b01;
        smb_on <= 1'b1;
        a = {SMB_ADDR_HI, 4'h6};
        wt(6);
        smb_wr({a, 1'b0}, 1'b1);
        chk("lane1 via bus", 32'h3C, {24'h0, lane_cfg[1]});
        smb_wr({a ^ 7'h01, 1'b0}, 1'b0);
        i_lcm_smb_host.start();
        i_lcm_smb_host.wbyte({a, 1'b1}, ack);
        i_lcm_smb_host.wbyte(8'hFF, ack);
        i_lcm_smb_host.stop();
        chk("lane2 via bus", 32'hA5, {24'h0, i_lcm_smb_host.rx});
        config_bus_mode_select <= 1'b0;
        wt(6);
        smb_wr({a, 1'b0}, 1'b0);
    endtask
    initial begin
        {presetn, psel, penable, pwrite, config_bus_mode_select, rate_select_pin, smb_on} = 7'h0;
        {side_a_equalizer_level_straps, side_b_equalizer_level_straps, side_b_deemphasis_level_straps} = 6'h0;
        {paddr, pwdata, dem_a, rx_idle} = 44'h0;
        rate_select_float = 1'b1;
        num_errors = 0;
        checked = 0;
        wt(6);
        presetn <= 1'b1;
        wt(1);
        t_pin();
        t_reg();
        t_smb();
        print_verdict();
    end
endmodule
